// ### core/srmc_pkg.sv
package srmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_MHZ    = 100;
  localparam int SETTLE_US  = 200;
  localparam int PRECOND_US = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam logic [15:0] PRECOND_CYCLES = 16'(PRECOND_US * CLK_MHZ);

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 11;
  localparam int WORDS  = 1024;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  localparam logic [5:0] REG_CONFIG = 6'h00;
  localparam logic [5:0] REG_TEST   = 6'h02;
  localparam logic [5:0] REG_BASE   = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h06;

  localparam int CFG_STOP_BIT  = 15;
  localparam int CFG_SPACE_BIT = 8;
  localparam logic CFG_SPACE_RESET = 1'h1;
  localparam logic CFG_STOP_RESET  = 1'h0;
  localparam int TST_LOCK_BIT  = 8;
  localparam int ST_PRE_DONE = 0;
  localparam int ST_SETTLED  = 1;
  localparam int ST_CUR_HIGH = 2;
  localparam int ST_BUSY     = 3;

  localparam logic [6:0] TC_NONE = 7'h00;
  localparam logic [6:0] TC_OC1  = 7'h27;
  localparam logic [6:0] TC_OC2  = 7'h37;
  localparam logic [6:0] TC_OC3  = 7'h2f;
  localparam logic [6:0] TC_OC4  = 7'h3f;
  localparam logic [6:0] TC_PRE  = 7'h64;
  localparam logic [6:0] TC_CUR  = 7'h44;

  typedef enum logic [1:0] {SRMC_IDLE, SRMC_ADDR, SRMC_DATA} srmc_phase_e;

endpackage

// ### core/srmc_ram.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module srmc_ram
#(
  parameter int SETTLE_CYCLES = srmc_pkg::SETTLE_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sys_reset_req,
  input  wire logic        test_mode,
  input  wire logic        emul_mode,
  input  wire logic        cur_high_in,
  input  wire logic        bus_req,
  input  wire logic        bus_wr,
  input  wire logic        bus_super,
  input  wire logic [1:0]  bus_size,
  input  wire logic [10:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_hit,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        cop_rd,
  input  wire logic [9:0]  cop_addr,
  output logic             cop_valid,
  output logic [15:0]      cop_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    srmc_pkg::srmc_phase_e phase;
    logic                  part;
    logic [10:0]           addr;
    logic                  wr;
    logic [1:0]            size;
    logic [31:0]           wdata;
    logic [31:0]           rdata;
    logic                  stop;
    logic                  space;
    logic                  lock_ctl;
    logic [6:0]            sel;
    logic [15:0]           pre_cnt;
    logic                  pre_done;
    logic [15:0]           settle_cnt;
    logic                  settle_done;
    logic                  pre_ok;
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic                  cur_high;
    logic [15:0]           reg_rdata;
    logic                  cop_valid;
    logic [15:0]           cop_rdata;
  } srmc_state_s;

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

  srmc_state_s r;
  srmc_state_s next_r;

  logic [15:0] mem [srmc_pkg::WORDS];
  logic        mem_we;
  logic [1:0]  mem_be;
  logic [9:0]  mem_idx;
  logic [15:0] mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic two_parts(input logic [1:0] size, input logic a0);
    two_parts = (size == srmc_pkg::SZ_LONG) || (size == srmc_pkg::SZ_WORD && a0);
  endfunction

  function automatic logic byte_op(input logic [1:0] size, input logic a0);
    byte_op = (size == srmc_pkg::SZ_BYTE) || (size == srmc_pkg::SZ_WORD && a0);
  endfunction

  // byte address of the part in flight; wraps inside the array
  function automatic logic [10:0] part_addr(input logic [10:0] a,
                                            input logic [1:0] size,
                                            input logic part);
    logic [10:0] step;
    step = (size == srmc_pkg::SZ_LONG) ? 11'h002 : 11'h001;
    part_addr = part ? a + step : a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        last;
  logic        test_on;
  logic        cur_result;
  logic [10:0] pa;
  logic [15:0] word_rd;
  logic [15:0] tdata;
  logic [7:0]  lane_rd;
  logic [15:0] part_wd;

  always_comb
  begin
    next_r  = r;
    mem_we  = 1'b0;
    mem_be  = 2'h0;
    mem_wd  = 16'h0000;
    next_r.reg_rdata = 16'h0000;
    next_r.cop_valid = 1'b0;

    // pin input: 3 stages, change accepted when stages 2 and 3 agree
    next_r.s1 = cur_high_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      next_r.cur_high = r.s3;
    end

    last    = !two_parts(r.size, r.addr[0]) || r.part;
    test_on = test_mode && !emul_mode && r.sel != srmc_pkg::TC_NONE;
    pa      = part_addr(r.addr, r.size, r.part);
    mem_idx = pa[10:1];
    word_rd = mem[mem_idx];
    // unpreconditioned or unsettled current test reports the failing value
    cur_result = !r.settle_done || !r.pre_ok || r.cur_high;

    unique case (r.sel)
      srmc_pkg::TC_OC1, srmc_pkg::TC_OC3: tdata = 16'h0000;
      srmc_pkg::TC_OC2, srmc_pkg::TC_OC4: tdata = 16'hffff;
      srmc_pkg::TC_PRE: tdata = {7'h00, r.pre_done, 7'h00, r.pre_done};
      srmc_pkg::TC_CUR: tdata = {7'h00, cur_result, 7'h00, cur_result};
      default:          tdata = word_rd;
    endcase
    if (test_on)
    begin
      word_rd = tdata;
    end
    lane_rd = pa[0] ? word_rd[7:0] : word_rd[15:8];

    if (r.size == srmc_pkg::SZ_LONG)
    begin
      part_wd = r.part ? r.wdata[15:0] : r.wdata[31:16];
    end
    else if (r.size == srmc_pkg::SZ_WORD && !r.addr[0])
    begin
      part_wd = r.wdata[15:0];
    end
    else
    begin
      part_wd = (r.size == srmc_pkg::SZ_WORD && !r.part) ?
                {r.wdata[15:8], r.wdata[15:8]} : {r.wdata[7:0], r.wdata[7:0]};
    end

    //////////////////////////////////////////////////////////////////////////
    // array bus cycle: address clock then data clock
    unique case (r.phase)
      srmc_pkg::SRMC_IDLE:
      begin
        if (bus_hit)
        begin
          next_r.phase = srmc_pkg::SRMC_ADDR;
          next_r.part  = 1'b0;
          next_r.addr  = bus_addr;
          next_r.wr    = bus_wr;
          next_r.size  = bus_size;
          next_r.wdata = bus_wdata;
          next_r.rdata = 32'h0000_0000;
        end
      end
      srmc_pkg::SRMC_ADDR:
      begin
        next_r.phase = srmc_pkg::SRMC_DATA;
        if (r.wr)
        begin
          // writes are dropped while a test owns the array
          mem_we = !test_on;
          mem_wd = part_wd;
          if (byte_op(r.size, r.addr[0]))
          begin
            mem_be = pa[0] ? 2'h1 : 2'h2;
          end
          else
          begin
            mem_be = 2'h3;
          end
        end
        else if (r.size == srmc_pkg::SZ_LONG)
        begin
          if (r.part)
          begin
            next_r.rdata[15:0] = word_rd;
          end
          else
          begin
            next_r.rdata[31:16] = word_rd;
          end
        end
        else if (r.size == srmc_pkg::SZ_WORD && !r.addr[0])
        begin
          next_r.rdata[15:0] = word_rd;
        end
        else if (r.size == srmc_pkg::SZ_WORD && !r.part)
        begin
          next_r.rdata[15:8] = lane_rd;
        end
        else
        begin
          next_r.rdata[7:0] = lane_rd;
        end
      end
      srmc_pkg::SRMC_DATA:
      begin
        if (last)
        begin
          next_r.phase = srmc_pkg::SRMC_IDLE;
        end
        else if (sys_reset_req && r.size == srmc_pkg::SZ_LONG)
        begin
          // long only: finished word stays written, second word abandoned;
          // a misaligned word is a single access and must complete
          next_r.phase = srmc_pkg::SRMC_IDLE;
        end
        else
        begin
          next_r.phase = srmc_pkg::SRMC_ADDR;
          next_r.part  = 1'b1;
        end
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // test sequencing counters
    if (r.sel == srmc_pkg::TC_PRE && !r.pre_done)
    begin
      if (r.pre_cnt == srmc_pkg::PRECOND_CYCLES - 16'h0001)
      begin
        next_r.pre_done = 1'b1;
      end
      else
      begin
        next_r.pre_cnt = r.pre_cnt + 16'h0001;
      end
    end
    if (r.sel == srmc_pkg::TC_CUR && !r.settle_done)
    begin
      if (r.settle_cnt == SETTLE_LAST)
      begin
        next_r.settle_done = 1'b1;
      end
      else
      begin
        next_r.settle_cnt = r.settle_cnt + 16'h0001;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // register port
    if (reg_wr && reg_addr == srmc_pkg::REG_CONFIG)
    begin
      next_r.stop  = reg_wdata[srmc_pkg::CFG_STOP_BIT];
      next_r.space = reg_wdata[srmc_pkg::CFG_SPACE_BIT];
    end
    if (reg_wr && reg_addr == srmc_pkg::REG_TEST && test_mode)
    begin
      next_r.lock_ctl = reg_wdata[srmc_pkg::TST_LOCK_BIT];
      unique case (reg_wdata[6:0])
        srmc_pkg::TC_NONE:
        begin
          next_r.sel = srmc_pkg::TC_NONE;
        end
        srmc_pkg::TC_OC1, srmc_pkg::TC_OC2, srmc_pkg::TC_OC3, srmc_pkg::TC_OC4:
        begin
          next_r.sel = reg_wdata[6:0];
        end
        srmc_pkg::TC_PRE:
        begin
          next_r.sel      = srmc_pkg::TC_PRE;
          next_r.pre_cnt  = 16'h0000;
          next_r.pre_done = 1'b0;
        end
        srmc_pkg::TC_CUR:
        begin
          next_r.sel         = srmc_pkg::TC_CUR;
          next_r.settle_cnt  = 16'h0000;
          next_r.settle_done = 1'b0;
          next_r.pre_ok      = r.sel == srmc_pkg::TC_PRE && r.pre_done;
        end
        default:
        begin
          next_r.sel = r.sel;
        end
      endcase
    end
    if (!test_mode)
    begin
      next_r.sel      = srmc_pkg::TC_NONE;
      next_r.lock_ctl = 1'b0;
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        srmc_pkg::REG_CONFIG:
        begin
          next_r.reg_rdata[srmc_pkg::CFG_STOP_BIT]  = r.stop;
          next_r.reg_rdata[srmc_pkg::CFG_SPACE_BIT] = r.space;
        end
        srmc_pkg::REG_TEST:
        begin
          if (test_mode)
          begin
            next_r.reg_rdata[srmc_pkg::TST_LOCK_BIT] = r.lock_ctl;
            next_r.reg_rdata[6:0] = r.sel;
          end
        end
        srmc_pkg::REG_STATUS:
        begin
          next_r.reg_rdata[srmc_pkg::ST_PRE_DONE] = r.pre_done;
          next_r.reg_rdata[srmc_pkg::ST_SETTLED]  = r.settle_done;
          next_r.reg_rdata[srmc_pkg::ST_CUR_HIGH] = r.cur_high;
          next_r.reg_rdata[srmc_pkg::ST_BUSY] = r.phase != srmc_pkg::SRMC_IDLE;
        end
        default:
        begin
          next_r.reg_rdata = 16'h0000;
        end
      endcase
    end

    // system reset restores controls once no bus cycle is open
    if (sys_reset_req && next_r.phase == srmc_pkg::SRMC_IDLE)
    begin
      next_r.stop        = srmc_pkg::CFG_STOP_RESET;
      next_r.space       = srmc_pkg::CFG_SPACE_RESET;
      next_r.sel         = srmc_pkg::TC_NONE;
      next_r.lock_ctl    = 1'b0;
      next_r.pre_done    = 1'b0;
      next_r.settle_done = 1'b0;
      next_r.pre_ok      = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // dedicated coprocessor port, one-clock read like its microcode rom
    if (emul_mode && cop_rd)
    begin
      next_r.cop_valid = 1'b1;
      next_r.cop_rdata = mem[cop_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // claim only in normal modes so outside logic may decode the range
  assign bus_hit = bus_req && r.phase == srmc_pkg::SRMC_IDLE && !sys_reset_req
                   && !emul_mode && !r.stop && (!r.space || bus_super);
  assign bus_ack   = r.phase == srmc_pkg::SRMC_DATA && last;
  assign bus_rdata = r.rdata;
  assign reg_rdata = r.reg_rdata;
  assign cop_valid = r.cop_valid;
  assign cop_rdata = r.cop_rdata;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      // hard reset cuts any access short; array contents not protected
      r       <= '0;
      r.space <= srmc_pkg::CFG_SPACE_RESET;
      r.stop  <= srmc_pkg::CFG_STOP_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // array has no reset: contents survive every reset kind
  always_ff @(posedge sys_clk)
  begin
    if (mem_we && mem_be[1])
    begin
      mem[mem_idx][15:8] <= mem_wd[15:8];
    end
    if (mem_we && mem_be[0])
    begin
      mem[mem_idx][7:0] <= mem_wd[7:0];
    end
  end

endmodule // srmc_ram
`default_nettype wire

// ### tb/srmc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// bus master: holds a request for one clock edge only, taken or not, then scrambles the address and write data lines
module srmc_cpu_model
(
  input  wire logic        sys_clk,
  input  wire logic        bus_ack,
  input  wire logic [31:0] bus_rdata,
  output var logic         bus_req,
  output var logic         bus_wr,
  output var logic         bus_super,
  output var logic [1:0]   bus_size,
  output var logic [10:0]  bus_addr,
  output var logic [31:0]  bus_wdata
);
  initial
  begin
    bus_req = 1'b0;
    bus_wr = 1'b0;
    bus_super = 1'b1;
    bus_size = 2'h0;
    bus_addr = 11'h0;
    bus_wdata = 32'h0;
  end
  task automatic access(input logic wr, input logic [1:0] sz, input logic [10:0] a,
                        input logic [31:0] wd, input int gap,
                        output logic [31:0] rd, output int cyc);
    cyc = 0;
    rd = 32'h0;
    repeat (gap + 1) @(posedge sys_clk);
    bus_req <= 1'b1;
    bus_wr <= wr;
    bus_size <= sz;
    bus_addr <= a;
    bus_wdata <= wd;
    @(posedge sys_clk);
    bus_req <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~wd;
    for (int i = 1; i <= 6 && cyc == 0; i++)
    begin
      @(posedge sys_clk);
      if (bus_ack === 1'b1)
      begin
        cyc = i;
        rd = bus_rdata;
      end
    end
  endtask
endmodule // srmc_cpu_model
`default_nettype wire

// ### tb/srmc_ram_properties.sv
`timescale 1ns/100ps
`default_nettype none
module srmc_ram_properties
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        sys_reset_req,
  input wire logic        emul_mode,
  input wire logic        test_mode,
  input wire logic        bus_req,
  input wire logic [1:0]  bus_size,
  input wire logic [10:0] bus_addr,
  input wire logic        bus_hit,
  input wire logic        bus_ack,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        cop_rd,
  input wire logic        cop_valid
);
  // stop shadow; a reset request clears it early, which only weakens the check
  logic stop_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || sys_reset_req)
      stop_q <= 1'b0;
    else if (reg_wr && reg_addr == srmc_pkg::REG_CONFIG)
      stop_q <= reg_wdata[srmc_pkg::CFG_STOP_BIT];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    bus_req && bus_hit;
  endsequence
  chk_short_cycle:
    assert property (s_take ##0 (bus_size == srmc_pkg::SZ_BYTE ||
      (bus_size == srmc_pkg::SZ_WORD && !bus_addr[0])) |=> !bus_ack ##1 bus_ack)
      else $error("short access did not ack on its second clock");
  // a reset request drops the second part of a long access, so it cancels the check
  chk_long_cycle:
    assert property (@(posedge sys_clk) disable iff (!rst_n || sys_reset_req)
      s_take ##0 (bus_size == srmc_pkg::SZ_LONG ||
      (bus_size == srmc_pkg::SZ_WORD && bus_addr[0])) |=> (!bus_ack)[*3] ##1 bus_ack)
      else $error("long access did not ack on its fourth clock");
  chk_odd_word:
    assert property (s_take ##0 (bus_size == srmc_pkg::SZ_WORD && bus_addr[0])
      |=> (!bus_ack)[*3] ##1 bus_ack)
      else $error("misaligned word did not complete on its fourth clock");
  chk_busy_refuse:
    assert property (s_take |=> (!bus_hit)[*2])
      else $error("access claimed while busy");
  chk_stop_silent:
    assert property (stop_q |-> !bus_hit)
      else $error("array answered in stop mode");
  chk_emul_silent:
    assert property (emul_mode |-> !bus_hit)
      else $error("array answered the bus in emulation mode");
  chk_cop_answer:
    assert property (cop_rd && emul_mode |=> cop_valid)
      else $error("coprocessor read not answered next cycle");
  chk_cop_quiet:
    assert property (!(cop_rd && emul_mode) |=> !cop_valid)
      else $error("coprocessor answer without emulation read");
  chk_test_locked:
    assert property (reg_rd && reg_addr == srmc_pkg::REG_TEST && !test_mode
      |=> reg_rdata == 16'h0)
      else $error("test register readable outside test mode");
endmodule // srmc_ram_properties
`default_nettype wire

// ### tb/srmc_ram_test.sv
`timescale 1ns/100ps
`default_nettype none
module srmc_ram_test;
  localparam int SETTLE = 20;
  localparam logic [1:0] BY = srmc_pkg::SZ_BYTE, WO = srmc_pkg::SZ_WORD, LO = srmc_pkg::SZ_LONG;
  localparam logic [5:0] CFG = srmc_pkg::REG_CONFIG, TST = srmc_pkg::REG_TEST;
  logic        sys_clk, rst_n, sys_reset_req, test_mode, emul_mode, cur_high_in;
  logic        bus_req, bus_wr, bus_super, bus_hit, bus_ack, reg_wr, reg_rd, cop_rd, cop_valid;
  logic [1:0]  bus_size;
  logic [10:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, d;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cop_rdata;
  logic [9:0]  cop_addr;
  int          c, error_cnt, compares;
  srmc_ram #(.SETTLE_CYCLES(SETTLE)) srmc_ram_i
  (
    .sys_clk, .rst_n, .sys_reset_req, .test_mode, .emul_mode, .cur_high_in, .bus_req,
    .bus_wr, .bus_super, .bus_size, .bus_addr, .bus_wdata, .bus_hit, .bus_ack, .bus_rdata,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cop_rd, .cop_addr, .cop_valid,
    .cop_rdata
  );
  srmc_cpu_model srmc_cpu_model_i
  (
    .sys_clk, .bus_ack, .bus_rdata, .bus_req, .bus_wr, .bus_super, .bus_size, .bus_addr,
    .bus_wdata
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ba(input logic wr, input logic [1:0] sz, input logic [10:0] a,
                    input logic [31:0] wd);
    srmc_cpu_model_i.access(wr, sz, a, wd, 0, d, c);
  endtask
  task automatic rw(input logic [5:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [5:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = {16'h0, reg_rdata};
  endtask
  task automatic cr(input logic [9:0] a);
    @(posedge sys_clk);
    cop_rd <= 1'b1;
    cop_addr <= a;
    @(posedge sys_clk);
    cop_rd <= 1'b0;
    @(posedge sys_clk);
    d = {15'h0, cop_valid, cop_rdata};
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_normal;
    rr(CFG);
    chk("config", 32'h0100, d);
    ba(1, LO, 11'h040, 32'hdeadbeef);
    chk("long clocks", 32'h4, 32'(c));
    ba(1, BY, 11'h011, 32'h5a);
    chk("byte clocks", 32'h2, 32'(c));
    ba(1, WO, 11'h031, 32'habcd);
    chk("odd clocks", 32'h4, 32'(c));
    ba(0, WO, 11'h040, 32'h0);
    chk("word", 32'hdead, d & 32'hffff);
    chk("word clocks", 32'h2, 32'(c));
    ba(0, BY, 11'h043, 32'h0);
    chk("byte", 32'hef, d & 32'hff);
    ba(0, WO, 11'h030, 32'h0);
    chk("odd pair", 32'hab, d & 32'hff);
    ba(0, WO, 11'h031, 32'h0);
    chk("odd word", 32'habcd, d & 32'hffff);
    chk("odd read clocks", 32'h4, 32'(c));
    srmc_cpu_model_i.access(0, LO, 11'h010, 32'h0, 3, d, c);
    chk("long", 32'h5a, (d >> 16) & 32'hff);
  endtask
  task automatic t_stop;
    rw(CFG, 16'h8000);
    ba(0, LO, 11'h040, 32'h0);
    chk("stop read", 32'h0, 32'(c));
    ba(1, LO, 11'h040, 32'h0);
    chk("stop write", 32'h0, 32'(c));
    rw(CFG, 16'h0000);
    ba(0, LO, 11'h040, 32'h0);
    chk("resume", 32'hdeadbeef, d);
  endtask
  task automatic t_emul;
    cr(10'h020);
    chk("cop idle", 32'h0, d & 32'h10000);
    @(posedge sys_clk) emul_mode <= 1'b1;
    ba(0, LO, 11'h040, 32'h0);
    chk("emul bus", 32'h0, 32'(c));
    rw(CFG, 16'h8000);
    cr(10'h020);
    chk("cop hi", 32'h1dead, d);
    cr(10'h021);
    chk("cop lo", 32'h1beef, d);
    rw(CFG, 16'h0000);
    @(posedge sys_clk) emul_mode <= 1'b0;
  endtask
  task automatic t_test;
    logic [6:0] oc [4] = '{srmc_pkg::TC_OC1, srmc_pkg::TC_OC2, srmc_pkg::TC_OC3,
                           srmc_pkg::TC_OC4};
    rw(TST, 16'h0027);
    rr(TST);
    chk("locked", 32'h0, d);
    ba(0, LO, 11'h040, 32'h0);
    chk("no test", 32'hdeadbeef, d);
    @(posedge sys_clk) test_mode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rw(TST, {9'h0, oc[i]});
      rr(TST);
      chk("select", {25'h0, oc[i]}, d);
      ba(0, LO, 11'(i * 508), 32'h0);
      chk("open test", i[0] ? 32'hffffffff : 32'h0, d);
    end
    rw(TST, 16'h0000);
    ba(1, LO, 11'h100, 32'h13579bdf);
    ba(0, LO, 11'h100, 32'h0);
    chk("normal", 32'h13579bdf, d);
    rw(TST, 16'h0055);
    rr(TST);
    chk("unlisted", 32'h0, d);
    ba(0, LO, 11'h100, 32'h0);
    chk("unlisted read", 32'h13579bdf, d);
  endtask
  task automatic t_current(input logic [31:0] pat, input logic hi);
    int n;
    for (int a = 0; a < 2048; a += 4)
      ba(1, LO, 11'(a), pat);
    cur_high_in <= hi;
    rw(TST, {9'h0, srmc_pkg::TC_PRE});
    ba(0, LO, 11'h0, 32'h0);
    chk("pretest busy", 32'h0, d & 32'h1);
    n = 0;
    while (d[0] !== 1'b1 && n < 500)
    begin
      ba(0, LO, 11'h0, 32'h0);
      n++;
    end
    chk("pretest done", 32'h1, d & 32'h1);
    rw(TST, {9'h0, srmc_pkg::TC_CUR});
    ba(0, LO, 11'h0, 32'h0);
    chk("unsettled", 32'h1, d & 32'h1);
    repeat (SETTLE) @(posedge sys_clk);
    ba(0, LO, 11'h0, 32'h0);
    chk("current", {31'h0, hi}, d & 32'h1);
    rr(srmc_pkg::REG_STATUS);
    chk("status", {28'h0, 1'b0, hi, 2'h3}, d);
    rw(TST, 16'h0000);
  endtask
  task automatic t_sysrst;
    fork
      ba(1, LO, 11'h200, 32'h11112222);
      begin
        repeat (3) @(posedge sys_clk);
        sys_reset_req <= 1'b1;
      end
    join
    chk("long cut", 32'h0, 32'(c));
    @(posedge sys_clk) sys_reset_req <= 1'b0;
    ba(0, LO, 11'h200, 32'h0);
    chk("half done", 32'h11110000, d);
    fork
      ba(1, BY, 11'h204, 32'h77);
      begin
        repeat (2) @(posedge sys_clk);
        sys_reset_req <= 1'b1;
      end
    join
    chk("byte done", 32'h2, 32'(c));
    @(posedge sys_clk) sys_reset_req <= 1'b0;
    ba(0, BY, 11'h204, 32'h0);
    chk("byte kept", 32'h77, d & 32'hff);
    fork
      ba(1, WO, 11'h205, 32'h3344);
      begin
        repeat (3) @(posedge sys_clk);
        sys_reset_req <= 1'b1;
      end
    join
    chk("odd word done", 32'h4, 32'(c));
    @(posedge sys_clk) sys_reset_req <= 1'b0;
    ba(0, WO, 11'h205, 32'h0);
    chk("odd word kept", 32'h3344, d & 32'hffff);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // the two array fills dominate the run, about 6100 of its roughly 8450 clocks
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  initial
  begin
    {rst_n, sys_reset_req, test_mode, emul_mode, cur_high_in, reg_wr, reg_rd, cop_rd} = 8'h0;
    reg_addr = 6'h0;
    reg_wdata = 16'h0;
    cop_addr = 10'h0;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_normal();
    t_stop();
    t_emul();
    t_test();
    t_current(32'hffffffff, 1'b0);
    t_current(32'h0, 1'b1);
    t_sysrst();
    conclude();
  end
endmodule // srmc_ram_test
bind srmc_ram srmc_ram_properties srmc_ram_properties_i
(
  .sys_clk, .rst_n, .sys_reset_req, .emul_mode, .test_mode, .bus_req, .bus_size, .bus_addr,
  .bus_hit, .bus_ack, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cop_rd, .cop_valid
);
`default_nettype wire
